// [rtl/usb_host_interrupter_moderation.sv]
// Interrupter mapping, routing and moderation with Avalon-MM registers
//
// Behaviour
// RQ1 - Up to 1024 interrupters; a read-only count reports how many exist.
// RQ2 - One vector per interrupter; request only when enabled and events need it.
// RQ3 - Pin mode: only interrupter 0 drives the pin; others held off.
// RQ4 - MSI mode: interrupters 0 to 31 usable, higher ones disabled.
// RQ5 - Reported MSI multiple-message-capable never exceeds interrupter count.
// RQ6 - MSI vector equals interrupter index modulo enabled message count.
// RQ7 - MSI-X: interrupter n uses entry n, allocated by its vector enable.
// RQ8 - Reported MSI-X table size equals interrupter count.
// RQ9 - At least one interrupter is implemented.
// RQ10 - No interrupt leaves unless the global enable bit is one.
// RQ11 - Transfer events go to the interrupter named by their target field.
// RQ12 - Without mapping support every event goes to interrupter 0.
// RQ13 - Out-of-range target: the event is dropped, nothing else affected.
// RQ14 - Slot context target is range-checked when a command supplies it.
// RQ15 - Moderation register holds 16-bit countdown and 16-bit interval.
// RQ16 - Each interval unit is 250 ns, independent of traffic.
// RQ17 - Interval resets to 4000, one millisecond; software may reload it.
// RQ18 - Armed, idle, enabled: set pending and busy, load countdown.
// RQ19 - Next interrupt needs countdown zero, arm high, busy low.
// RQ20 - Countdown at zero with arm low stays at zero.
// RQ21 - Message mode: pending issues one write, cleared when it completes.
// RQ22 - Pin mode: pending drives the pin; software clears it.
// RQ23 - Event placed without suppress flag sets the arm flag.
// RQ24 - Arm rising with zero countdown and idle handler sets pending at once.
// RQ25 - Arm clears when ring empties; software clears handler busy.
// RQ26 - Countdown drops by one per 250 ns tick and stops at zero.
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module usb_host_interrupter_moderation (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Event placement
    input  wire logic        evt_valid,
    input  wire logic [9:0]  evt_target,
    input  wire logic        evt_suppress,
    output logic             evt_dropped,
    // Slot context check
    input  wire logic        slot_chk_req,
    input  wire logic [9:0]  slot_chk_tgt,
    output logic             slot_chk_done,
    output logic             slot_chk_ok,
    // Message write and pin
    output logic             msg_valid,
    output logic      [9:0]  msg_vector,
    input  wire logic        msg_done,
    output logic             int_pin_n
);
    localparam int N = irq_mod_pkg::NUM_INTR; // RQ1 RQ9
    localparam logic MAP_SUP = (N > 1); // RQ11 RQ12

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic        wait_ff;
    logic [31:0] rdata_ff;
    logic        gie_ff;
    logic [1:0]  mode_ff;
    logic [2:0]  mme_ff;
    logic [N-1:0] ven_ff;
    logic [N-1:0] ien_ff;
    logic [7:0]  deq_ff [N];
    logic [7:0]  enq_ff [N];
    logic        msg_ff;
    logic [9:0]  vec_ff;
    logic [1:0]  sel_ff;
    logic        drop_ff;
    logic        sdone_ff;
    logic        sok_ff;
    logic        pin_n_ff;
    logic [4:0]  tdiv_ff;
    logic        tick_ff;

    // ------------------------------------------------------------
    // Combinational helpers
    // ------------------------------------------------------------
    logic [31:0] rd_cur;
    logic [31:0] bm;
    logic [31:0] wv;
    logic [31:0] w1;
    logic        wr_go;
    logic        in_win;
    logic [1:0]  widx;
    logic [3:0]  woff;
    logic [9:0]  tgt;
    logic        tgt_ok;
    logic        evt_go;
    logic [2:0]  mme_eff;
    logic [9:0]  vmask;
    logic [N-1:0] pend_v;
    logic [N-1:0] en_v;
    logic [N-1:0] sw_pclr;
    logic        any_p;
    logic [1:0]  pick;
    irq_mod_pkg::irq_mode_t mode;
    logic [15:0] cnt_rd  [N];
    logic [15:0] ival_rd [N];
    logic [N-1:0] busy_v;

    intr_ctl_if ic [N] ();

    assign mode   = irq_mod_pkg::irq_mode_t'(mode_ff);
    assign wr_go  = avs_write & ~wait_ff;
    assign in_win = (avs_address >= irq_mod_pkg::A_IBASE) && (avs_address < irq_mod_pkg::A_IEND);
    assign widx   = avs_address[5:4] - irq_mod_pkg::A_IBASE[5:4];
    assign woff   = avs_address[3:0];
    assign bm     = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wv     = (rd_cur & ~bm) | (avs_writedata & bm);
    assign w1     = avs_writedata & bm;

    // Target selection and range check
    assign tgt    = MAP_SUP ? evt_target : 10'h000; // RQ11 RQ12
    assign tgt_ok = (tgt < 10'(N)); // RQ13
    assign evt_go = evt_valid & tgt_ok;

    // MSI message count clamped to what is advertised
    assign mme_eff = (mme_ff > irq_mod_pkg::MSI_MMC) ? irq_mod_pkg::MSI_MMC : mme_ff;
    assign vmask   = 10'((10'h001 << mme_eff) - 10'h001);

    // ------------------------------------------------------------
    // Register readback
    // ------------------------------------------------------------
    always_comb begin
        rd_cur = 32'h0000_0000;
        if (in_win) begin
            unique case (woff)
                irq_mod_pkg::O_MAN: begin
                    rd_cur[irq_mod_pkg::B_PEND] = pend_v[widx];
                    rd_cur[irq_mod_pkg::B_IEN]  = ien_ff[widx];
                end
                irq_mod_pkg::O_MOD: rd_cur = {cnt_rd[widx], ival_rd[widx]}; // RQ15
                irq_mod_pkg::O_DEQ: begin
                    rd_cur[irq_mod_pkg::B_DEQ +: 8] = deq_ff[widx];
                    rd_cur[irq_mod_pkg::B_EHB]      = busy_v[widx];
                end
                irq_mod_pkg::O_ENQ: rd_cur[7:0] = enq_ff[widx];
                default: rd_cur = 32'h0000_0000;
            endcase
        end else begin
            unique case (avs_address)
                irq_mod_pkg::A_CMD:    rd_cur[irq_mod_pkg::B_GIE] = gie_ff;
                irq_mod_pkg::A_PARAMS: rd_cur[10:0] = 11'(N); // RQ1
                irq_mod_pkg::A_MODE: begin
                    rd_cur[1:0] = mode_ff;
                    rd_cur[irq_mod_pkg::B_MME +: 3] = mme_ff;
                    rd_cur[irq_mod_pkg::B_VEN +: N] = ven_ff;
                end
                irq_mod_pkg::A_CAPS: begin
                    rd_cur[2:0] = irq_mod_pkg::MSI_MMC; // RQ5
                    rd_cur[irq_mod_pkg::B_TSZ +: 11] = 11'(N); // RQ8
                end
                default: rd_cur = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Per-interrupter control and engines
    // ------------------------------------------------------------
    for (genvar n = 0; n < N; n++) begin : g_intr
        logic allowed;
        logic hit;

        // Mode-dependent permission for this interrupter
        always_comb begin
            unique case (mode)
                irq_mod_pkg::MODE_PIN:  allowed = (n == 0); // RQ3
                irq_mod_pkg::MODE_MSI:  allowed = (n < irq_mod_pkg::MSI_MAX_VEC); // RQ4
                irq_mod_pkg::MODE_MSIX: allowed = ven_ff[n]; // RQ7
                irq_mod_pkg::MODE_OFF:  allowed = 1'b0;
            endcase
        end

        assign hit        = wr_go & in_win & (widx == 2'(n));
        assign en_v[n]    = ien_ff[n] & gie_ff & allowed; // RQ2 RQ10
        assign pend_v[n]  = ic[n].pending;
        assign busy_v[n]  = ic[n].busy;
        assign cnt_rd[n]  = ic[n].count;
        assign ival_rd[n] = ic[n].ival;
        assign sw_pclr[n] = hit & (woff == irq_mod_pkg::O_MAN) & w1[irq_mod_pkg::B_PEND];

        assign ic[n].enable   = en_v[n];
        assign ic[n].tick     = tick_ff;
        assign ic[n].arm_set  = evt_go & (tgt == 10'(n)) & ~evt_suppress; // RQ23
        assign ic[n].arm_clr  = (deq_ff[n] == enq_ff[n]); // RQ25
        assign ic[n].pend_clr = sw_pclr[n] | (msg_ff & msg_done & (sel_ff == 2'(n))); // RQ21 RQ22
        assign ic[n].busy_clr = hit & (woff == irq_mod_pkg::O_DEQ) & w1[irq_mod_pkg::B_EHB]; // RQ25
        assign ic[n].ival_wr  = hit & (woff == irq_mod_pkg::O_MOD);
        assign ic[n].cnt_wr   = hit & (woff == irq_mod_pkg::O_MOD) & (|avs_byteenable[3:2]);
        assign ic[n].ival_d   = wv[15:0];
        assign ic[n].cnt_d    = wv[31:16];

        // Enable, dequeue pointer and enqueue index
        always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
                ien_ff[n] <= 1'b0;
                deq_ff[n] <= 8'h00;
                enq_ff[n] <= 8'h00;
            end else begin
                if (hit && woff == irq_mod_pkg::O_MAN) begin
                    ien_ff[n] <= wv[irq_mod_pkg::B_IEN];
                end
                if (hit && woff == irq_mod_pkg::O_DEQ) begin
                    deq_ff[n] <= wv[irq_mod_pkg::B_DEQ +: 8];
                end
                if (evt_go && tgt == 10'(n)) begin
                    enq_ff[n] <= enq_ff[n] + 8'h01; // RQ11
                end
            end
        end

        intr_moderator u_mod (
            .clock   (clock),
            .sys_rst (sys_rst),
            .ic      (ic[n])
        );
    end

    // ------------------------------------------------------------
    // Avalon-MM slave: one wait state, then answer
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wait_ff  <= ~((avs_read | avs_write) & wait_ff);
            rdata_ff <= avs_read ? rd_cur : 32'h0000_0000;
        end
    end

    // Global registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            gie_ff  <= 1'b0;
            mode_ff <= 2'h0;
            mme_ff  <= 3'h0;
            ven_ff  <= '0;
        end else if (wr_go && avs_address == irq_mod_pkg::A_CMD) begin
            gie_ff <= wv[irq_mod_pkg::B_GIE]; // RQ10
        end else if (wr_go && avs_address == irq_mod_pkg::A_MODE) begin
            mode_ff <= wv[1:0];
            mme_ff  <= wv[irq_mod_pkg::B_MME +: 3];
            ven_ff  <= wv[irq_mod_pkg::B_VEN +: N]; // RQ7
        end
    end

    // ------------------------------------------------------------
    // 250 ns tick divider
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tdiv_ff <= 5'h00;
            tick_ff <= 1'b0;
        end else if (tdiv_ff == 5'(irq_mod_pkg::TICK_CYC - 1)) begin
            tdiv_ff <= 5'h00;
            tick_ff <= 1'b1; // RQ16 RQ26
        end else begin
            tdiv_ff <= tdiv_ff + 5'h01;
            tick_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Message writes: lowest pending interrupter first
    // ------------------------------------------------------------
    always_comb begin
        any_p = 1'b0;
        pick  = 2'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend_v[i] && en_v[i]) begin
                any_p = 1'b1;
                pick  = 2'(i);
            end
        end
    end

    // One doubleword write outstanding at a time
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            msg_ff <= 1'b0;
            vec_ff <= 10'h000;
            sel_ff <= 2'h0;
        end else if (msg_ff) begin
            if (msg_done) begin
                msg_ff <= 1'b0; // RQ21
            end
        end else if (any_p && (mode == irq_mod_pkg::MODE_MSI || mode == irq_mod_pkg::MODE_MSIX)) begin
            msg_ff <= 1'b1;
            sel_ff <= pick;
            vec_ff <= (mode == irq_mod_pkg::MODE_MSI) ? (10'(pick) & vmask) : 10'(pick); // RQ6 RQ7
        end
    end

    // Pin follows pending of interrupter 0 only
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pin_n_ff <= 1'b1;
        end else begin
            pin_n_ff <= ~((mode == irq_mod_pkg::MODE_PIN) & pend_v[0] & en_v[0]); // RQ3 RQ22
        end
    end

    // Dropped events and slot context check
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            drop_ff  <= 1'b0;
            sdone_ff <= 1'b0;
            sok_ff   <= 1'b0;
        end else begin
            drop_ff  <= evt_valid & ~tgt_ok; // RQ13
            sdone_ff <= slot_chk_req;
            if (slot_chk_req) begin
                sok_ff <= (slot_chk_tgt < 10'(N)); // RQ14
            end
        end
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign evt_dropped     = drop_ff;
    assign slot_chk_done   = sdone_ff;
    assign slot_chk_ok     = sok_ff;
    assign msg_valid       = msg_ff;
    assign msg_vector      = vec_ff;
    assign int_pin_n       = pin_n_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_pin_only_zero: assert property (@(posedge clock) disable iff (sys_rst) // RQ3
        !int_pin_n |-> $past(mode == irq_mod_pkg::MODE_PIN && pend_v[0]))
        else $error("pin asserted outside pin mode");
    chk_global_gate: assert property (@(posedge clock) disable iff (sys_rst) // RQ10
        $rose(msg_valid) |-> $past(gie_ff)) else $error("message without global enable");
    chk_msg_release: assert property (@(posedge clock) disable iff (sys_rst) // RQ21
        msg_valid && msg_done |=> !msg_valid) else $error("message held after completion");
    chk_bad_target: assert property (@(posedge clock) disable iff (sys_rst) // RQ13
        evt_valid && !tgt_ok |=> evt_dropped)
        else $error("out of range event not dropped");
    chk_msi_vector: assert property (@(posedge clock) disable iff (sys_rst) // RQ6
        $rose(msg_valid) && mode == irq_mod_pkg::MODE_MSI |-> (msg_vector & ~vmask) == 10'h000)
        else $error("MSI vector outside enabled range");
    chk_bus_answer: assert property (@(posedge clock) disable iff (sys_rst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one wait state");
endmodule

// [rtl/irq_mod_pkg.sv]
// Constants, offsets and types shared by the interrupter block
package irq_mod_pkg;
    localparam int NUM_INTR    = 4;
    localparam int MAX_INTR    = 1024;
    localparam int MSI_MAX_VEC = 32;
    localparam logic [2:0] MSI_MMC = 3'h2;
    localparam int CLK_NS      = 50;
    localparam int TICK_NS     = 250;
    localparam int TICK_CYC    = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [15:0] IVAL_RST = 16'hFA0;
    localparam logic [7:0] A_CMD    = 8'h00;
    localparam logic [7:0] A_PARAMS = 8'h04;
    localparam logic [7:0] A_MODE   = 8'h08;
    localparam logic [7:0] A_CAPS   = 8'h0C;
    localparam logic [7:0] A_IBASE  = 8'h20;
    localparam logic [7:0] A_IEND   = 8'h60;
    localparam logic [3:0] O_MAN    = 4'h0;
    localparam logic [3:0] O_MOD    = 4'h4;
    localparam logic [3:0] O_DEQ    = 4'h8;
    localparam logic [3:0] O_ENQ    = 4'hC;
    localparam int B_GIE  = 2;
    localparam int B_PEND = 0;
    localparam int B_IEN  = 1;
    localparam int B_EHB  = 3;
    localparam int B_MME  = 4;
    localparam int B_VEN  = 16;
    localparam int B_TSZ  = 16;
    localparam int B_DEQ  = 8;
    typedef enum logic [1:0] {MODE_OFF, MODE_PIN, MODE_MSI, MODE_MSIX} irq_mode_t;
endpackage

// [rtl/intr_ctl_if.sv]
// Control and status bundle between controller and one moderation engine
`timescale 1ns/100ps
interface intr_ctl_if;
    logic        enable;
    logic        tick;
    logic        arm_set;
    logic        arm_clr;
    logic        pend_clr;
    logic        busy_clr;
    logic        ival_wr;
    logic        cnt_wr;
    logic [15:0] ival_d;
    logic [15:0] cnt_d;
    logic        pending;
    logic        busy;
    logic [15:0] count;
    logic [15:0] ival;
    modport ctrl (output enable, tick, arm_set, arm_clr, pend_clr, busy_clr,
                  output ival_wr, cnt_wr, ival_d, cnt_d,
                  input pending, busy, count, ival);
    modport engine (input enable, tick, arm_set, arm_clr, pend_clr, busy_clr,
                    input ival_wr, cnt_wr, ival_d, cnt_d,
                    output pending, busy, count, ival);
endinterface

// [rtl/intr_moderator.sv]
// Moderation engine of one interrupter
`timescale 1ns/100ps
module intr_moderator (
    // Clock and reset
    input  wire logic   clock,
    input  wire logic   sys_rst,
    // Controller side
    intr_ctl_if.engine  ic
);
    logic        arm_ff;
    logic        pend_ff;
    logic        busy_ff;
    logic [15:0] cnt_ff;
    logic [15:0] ival_ff;
    logic        fire;

    // Fire when armed, ring not empty, idle handler and expired counter
    assign fire = ic.enable & arm_ff & ~ic.arm_clr & ~busy_ff & (cnt_ff == 16'h0000); // RQ2 RQ18 RQ19 RQ24 RQ25

    assign ic.pending = pend_ff;
    assign ic.busy    = busy_ff;
    assign ic.count   = cnt_ff;
    assign ic.ival    = ival_ff;

    // Arm flag, an event beats an emptying ring
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            arm_ff <= 1'b0;
        end else if (ic.arm_set) begin
            arm_ff <= 1'b1; // RQ23
        end else if (ic.arm_clr) begin
            arm_ff <= 1'b0; // RQ25
        end
    end

    // Pending and busy flags, set wins over clear
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pend_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            pend_ff <= fire | (pend_ff & ~ic.pend_clr); // RQ18 RQ21 RQ22
            busy_ff <= fire | (busy_ff & ~ic.busy_clr); // RQ25
        end
    end

    // Countdown: load on fire, count ticks, rest at zero
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff <= 16'h0000;
        end else if (fire) begin
            cnt_ff <= ival_ff; // RQ18 RQ19
        end else if (ic.cnt_wr) begin
            cnt_ff <= ic.cnt_d;
        end else if (ic.tick && cnt_ff != 16'h0000) begin
            cnt_ff <= cnt_ff - 16'h0001; // RQ16 RQ20 RQ26
        end
    end

    // Interval field, software loaded
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ival_ff <= irq_mod_pkg::IVAL_RST; // RQ17
        end else if (ic.ival_wr) begin
            ival_ff <= ic.ival_d; // RQ15
        end
    end

    sequence s_fire;
        fire;
    endsequence
    sequence s_loaded;
        pend_ff && busy_ff && cnt_ff == $past(ival_ff);
    endsequence

    chk_fire_loads_flags: assert property (@(posedge clock) disable iff (sys_rst) // RQ18
        s_fire |=> s_loaded) else $error("fire did not set flags and load counter");
    chk_zero_rests: assert property (@(posedge clock) disable iff (sys_rst) // RQ20
        cnt_ff == 16'h0000 && !fire && !ic.cnt_wr |=> cnt_ff == 16'h0000)
        else $error("counter left zero without a fire");
    chk_rise_needs_cond: assert property (@(posedge clock) disable iff (sys_rst) // RQ19
        $rose(pend_ff) |-> $past(arm_ff && !busy_ff && cnt_ff == 16'h0000 && ic.enable))
        else $error("pending rose without moderation conditions");
    chk_count_step: assert property (@(posedge clock) disable iff (sys_rst) // RQ26
        ic.tick && cnt_ff != 16'h0000 && !fire && !ic.cnt_wr |=> cnt_ff == $past(cnt_ff) - 16'h0001)
        else $error("counter did not step down on tick");
endmodule

// [tb/msg_sink.sv]
// Host bus model that completes interrupt message writes
`timescale 1ns/100ps
module msg_sink (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Message request and chosen latency
    input  wire logic       msg_valid,
    input  wire logic [3:0] lat,
    output logic            msg_done
);
    logic [3:0] wait_ff;

    // One completion pulse per dword write, lat+1 cycles after the request
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wait_ff  <= 4'h0;
            msg_done <= 1'b0;
        end else if (msg_valid && !msg_done && wait_ff >= lat) begin
            wait_ff  <= 4'h0;
            msg_done <= 1'b1;
        end else begin
            msg_done <= 1'b0;
            wait_ff  <= (msg_valid && !msg_done) ? wait_ff + 4'h1 : 4'h0;
        end
    end
endmodule

// [tb/tb.sv]
// Self-checking bench for the interrupter moderation block
`timescale 1ns/100ps
module tb;
    logic        clock, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic        evt_valid, evt_suppress, evt_dropped, slot_chk_req, slot_chk_done, slot_chk_ok;
    logic [9:0]  evt_target, slot_chk_tgt, msg_vector;
    logic        msg_valid, msg_done, int_pin_n;
    logic [3:0]  lat;
    logic [15:0] rv;
    logic [31:0] exp_rd[$], exp_msg[$];
    logic [9:0]  tg[2] = '{10'h2, 10'h4};
    int          num_checks = 0, n_mismatch = 0, n_msg = 0;

    usb_host_interrupter_moderation uut (
        .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .evt_valid(evt_valid),
        .evt_target(evt_target), .evt_suppress(evt_suppress), .evt_dropped(evt_dropped),
        .slot_chk_req(slot_chk_req), .slot_chk_tgt(slot_chk_tgt), .slot_chk_done(slot_chk_done),
        .slot_chk_ok(slot_chk_ok), .msg_valid(msg_valid), .msg_vector(msg_vector),
        .msg_done(msg_done), .int_pin_n(int_pin_n));
    msg_sink sink (.clock(clock), .sys_rst(sys_rst), .msg_valid(msg_valid), .lat(lat), .msg_done(msg_done));

    // ----------------------------------------
    // Clock, checks and closing
    // ----------------------------------------
    always #25 clock = ~clock;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Outcome monitor: read data and completed messages against notes
    always @(posedge clock) begin
        if (avs_read && !avs_waitrequest) chk("readdata", exp_rd.pop_front(), avs_readdata);
        if (msg_valid && msg_done) begin
            n_msg++;
            if (exp_msg.size() == 0) chk("unexpected msg", 32'h0, 32'h1);
            else chk("msg_vector", exp_msg.pop_front(), {22'h0, msg_vector});
        end
    end

    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        for (i = 0; i < 50; i++) begin
            @(posedge clock);
            if (avs_waitrequest === 1'b0) break;
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (i == 50) begin
            chk("bus wait", 32'h1, 32'h0);
            close_out();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic evt(input logic [9:0] t, input logic s);
        @(posedge clock);
        evt_valid <= 1'b1;
        evt_target <= t;
        evt_suppress <= s;
        @(posedge clock);
        evt_valid <= 1'b0;
    endtask

    // Bounded wait: 0 message done, 1 pin low, 2 drop pulse, 3 slot done
    task automatic wt(input int k);
        int i, b;
        b = n_msg;
        for (i = 0; i < 300; i++) begin
            @(posedge clock);
            if ((k == 0 && n_msg != b) || (k == 1 && int_pin_n === 1'b0) ||
                (k == 2 && evt_dropped === 1'b1) || (k == 3 && slot_chk_done === 1'b1)) return;
        end
        chk("wait", 32'h1, 32'h0);
        close_out();
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        clock = 0; sys_rst = 1; avs_address = 8'h00; avs_read = 0; avs_write = 0;
        avs_writedata = 32'h0; evt_valid = 0; evt_target = 10'h0; evt_suppress = 0;
        slot_chk_req = 0; slot_chk_tgt = 10'h0; lat = 4'h0;
        void'($urandom(32'h6A0C));
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        bus(1'b1, irq_mod_pkg::A_PARAMS, 32'hFFFFFFFF);
        rd(irq_mod_pkg::A_PARAMS, 32'h4);
        rd(irq_mod_pkg::A_CAPS, 32'h0004_0002);
        rd(8'h24, 32'h0000_0FA0);
        rd(8'h10, 32'h0);
        rv = 16'($urandom_range(16'hFFFF));
        bus(1'b1, 8'h34, {16'h0, rv});
        rd(8'h34, {16'h0, rv});
        lat <= 4'($urandom_range(7));
        bus(1'b1, irq_mod_pkg::A_CMD, 32'h4);
        bus(1'b1, irq_mod_pkg::A_MODE, 32'h12);
        bus(1'b1, 8'h54, 32'h4);
        bus(1'b1, 8'h50, 32'h2);
        exp_msg.push_back(32'h1);
        evt(10'h3, 1'b0);
        wt(0);
        rd(8'h58, 32'h8);
        rd(8'h5C, 32'h1);
        evt(10'h3, 1'b0);
        evt(10'h3, 1'b1);
        repeat (40) @(posedge clock);
        bus(1'b1, 8'h58, 32'h0308);
        repeat (40) @(posedge clock);
        bus(1'b1, irq_mod_pkg::A_MODE, 32'h22);
        exp_msg.push_back(32'h3);
        evt(10'h3, 1'b0);
        wt(0);
        rd(8'h50, 32'h2);
        bus(1'b1, 8'h58, 32'h0408);
        bus(1'b1, irq_mod_pkg::A_CMD, 32'h0);
        evt(10'h3, 1'b0);
        repeat (40) @(posedge clock);
        evt(10'h5, 1'b0);
        wt(2);
        foreach (tg[j]) begin
            @(posedge clock);
            slot_chk_req <= 1'b1;
            slot_chk_tgt <= tg[j];
            @(posedge clock);
            slot_chk_req <= 1'b0;
            wt(3);
            chk("slot_ok", {31'h0, tg[j] < 10'h4}, {31'h0, slot_chk_ok});
        end
        bus(1'b1, irq_mod_pkg::A_MODE, 32'h1);
        bus(1'b1, irq_mod_pkg::A_CMD, 32'h4);
        bus(1'b1, 8'h20, 32'h2);
        evt(10'h0, 1'b0);
        wt(1);
        bus(1'b1, 8'h20, 32'h3);
        repeat (3) @(posedge clock);
        chk("int_pin_n", 32'h1, {31'h0, int_pin_n});
        bus(1'b1, irq_mod_pkg::A_MODE, 32'h0004_0003);
        bus(1'b1, 8'h40, 32'h2);
        exp_msg.push_back(32'h2);
        evt(10'h2, 1'b0);
        wt(0);
        close_out();
    end
endmodule
